// ### design/lsr_pkg.sv
package lsr_pkg;

   // ************************************************************
   // Geometry of the scan line
   // ************************************************************
   localparam int SEG_N      = 27;
   localparam int SEG_PIX    = 64;
   localparam int LINE_PIX   = SEG_N * SEG_PIX;
   localparam int SEG_W      = 5;
   localparam int IDX_W      = 6;
   localparam int ADDR_W     = 11;

   // ************************************************************
   // Data path
   // ************************************************************
   localparam int PIX_W      = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int GAP_W      = 24;

   localparam logic [SEG_W-1:0]  SEG_ZERO  = 5'h00;
   localparam logic [IDX_W-1:0]  IDX_ZERO  = 6'h00;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
   localparam logic [GAP_W-1:0]  GAP_ZERO  = 24'h000000;
   localparam logic [PIX_W-1:0]  PIX_ZERO  = 8'h00;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      LSR_IDLE,
      LSR_ARMED,
      LSR_SHIFT
   } lsr_state_t;

   typedef struct packed {
      logic             strobe;
      logic             first;
      logic             last;
      logic [PIX_W-1:0] level;
   } lsr_video_t;

   localparam lsr_video_t VIDEO_RESET = '{strobe: 1'b0, first: 1'b0, last: 1'b0, level: PIX_ZERO};

endpackage : lsr_pkg

// ### design/lsr_readout.sv
`timescale 1ns/1ps
// How it works
// - The line is 27 cascaded segments of 64 pixels, read segment after segment as one sequence.
// - Every scan line presents exactly 1728 pixel values on the video output, one per pixel clock.
// - The first pixel of each scan is the detector nearest the connector end, then onward away from it.
// - A buffered shift register of segment and pixel position selects each detector in turn.
// - On the pixel clock after the one that took the start pulse the first pixel value appears.
// - Each further pixel clock advances to the next pixel, which the controller samples and stores.
// - The interval between two start pulses sets the integration time and line period.

// ************************************************************
// Small FIFO in front of the detector memory
// ************************************************************
module lsr_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   // Fill side
   input  wire logic         in_valid,
   output wire logic         in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output wire logic         out_valid,
   input  wire logic         out_ready,
   output wire logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
         $error("lsr_fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [PW:0]   cnt_r;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_r + PW'(push);
         rp_r  <= rp_r + PW'(pop);
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   property p_fifo_bound;
      cnt_r <= (PW+1)'(DEPTH);
   endproperty
   a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");

endmodule : lsr_fifo

// ************************************************************
// Line scan readout
// ************************************************************
module lsr_readout
   import lsr_pkg::*;
#(
   parameter int FDEPTH = lsr_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    reset_n,
   // Sensor pins
   input  wire logic                    pixel_clock,
   input  wire logic                    line_start_pulse,
   // Detector levels, connector end first
   input  wire logic                    det_valid,
   output wire logic                    det_ready,
   input  wire logic [lsr_pkg::PIX_W-1:0] det_level,
   // Video and status
   output lsr_pkg::lsr_video_t          video_out,
   output wire logic                    line_active,
   output wire logic [lsr_pkg::GAP_W-1:0] integ_cycles
);
   import lsr_pkg::*;

   generate
      if (LINE_PIX > (1 << ADDR_W) || SEG_N > (1 << SEG_W) || SEG_PIX != (1 << IDX_W)) begin : g_chk
         $error("lsr_readout geometry does not fit its counters");
      end
   endgenerate

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic pc_s1;
   logic pc_s2;
   logic pc_s3;
   logic sp_s1;
   logic sp_s2;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_s1 <= 1'b0;
         pc_s2 <= 1'b0;
         pc_s3 <= 1'b0;
         sp_s1 <= 1'b0;
         sp_s2 <= 1'b0;
      end else begin
         pc_s1 <= pixel_clock;
         pc_s2 <= pc_s1;
         pc_s3 <= pc_s2;
         sp_s1 <= line_start_pulse;
         sp_s2 <= sp_s1;
      end
   end

   // Start is judged at the falling pixel clock edge, where the sensor latches it
   wire pc_fall = pc_s3 & ~pc_s2;
   wire sp_take = pc_fall & sp_s2;

   // ************************************************************
   // Detector memory, filled through the FIFO
   // ************************************************************
   logic [PIX_W-1:0]  pix_mem [LINE_PIX];
   logic [ADDR_W-1:0] wr_addr_r;
   logic              f_valid;
   logic [PIX_W-1:0]  f_data;
   lsr_state_t        state_r;
   lsr_state_t        state_nxt;

   // Levels are frozen while a line is shifted out; the FIFO absorbs the stall
   wire reading = (state_r != LSR_IDLE);
   wire mem_we  = f_valid & ~reading;
   wire wr_last = (wr_addr_r == ADDR_W'(LINE_PIX - 1));

   lsr_fifo #(
      .W     (PIX_W),
      .DEPTH (FDEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .in_valid  (det_valid),
      .in_ready  (det_ready),
      .in_data   (det_level),
      .out_valid (f_valid),
      .out_ready (~reading),
      .out_data  (f_data)
   );

   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         pix_mem[wr_addr_r] <= f_data;
      end
   end

   // ************************************************************
   // Segment and pixel shift position
   // ************************************************************
   logic [SEG_W-1:0]  seg_r;
   logic [IDX_W-1:0]  idx_r;
   logic [SEG_W-1:0]  seg_nxt;
   logic [IDX_W-1:0]  idx_nxt;
   lsr_video_t        video_r;
   lsr_video_t        video_nxt;

   wire [ADDR_W-1:0] rd_addr  = ADDR_W'({seg_r, IDX_ZERO}) + ADDR_W'(idx_r);
   wire              idx_end  = (idx_r == IDX_W'(SEG_PIX - 1));
   wire              seg_end  = (seg_r == SEG_W'(SEG_N - 1));
   wire              pix_last = idx_end & seg_end;
   wire              step     = pc_fall & ~sp_take & reading;

   always_comb begin
      state_nxt        = state_r;
      seg_nxt          = seg_r;
      idx_nxt          = idx_r;
      video_nxt        = video_r;
      video_nxt.strobe = 1'b0;
      if (sp_take) begin
         // A new start always restarts at the connector end
         state_nxt = LSR_ARMED;
         seg_nxt   = SEG_ZERO;
         idx_nxt   = IDX_ZERO;
      end else if (step) begin
         video_nxt.strobe = 1'b1;
         video_nxt.first  = (state_r == LSR_ARMED);
         video_nxt.last   = pix_last;
         video_nxt.level  = pix_mem[rd_addr];
         if (pix_last) begin
            state_nxt = LSR_IDLE;
         end else begin
            state_nxt = LSR_SHIFT;
            idx_nxt   = idx_r + IDX_W'(1);
            seg_nxt   = idx_end ? seg_r + SEG_W'(1) : seg_r;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r   <= LSR_IDLE;
         seg_r     <= SEG_ZERO;
         idx_r     <= IDX_ZERO;
         video_r   <= VIDEO_RESET;
         wr_addr_r <= ADDR_ZERO;
      end else begin
         state_r   <= state_nxt;
         seg_r     <= seg_nxt;
         idx_r     <= idx_nxt;
         video_r   <= video_nxt;
         wr_addr_r <= mem_we ? (wr_last ? ADDR_ZERO : wr_addr_r + ADDR_W'(1)) : wr_addr_r;
      end
   end

   // ************************************************************
   // Line period between start pulses
   // ************************************************************
   logic [GAP_W-1:0] gap_r;
   logic [GAP_W-1:0] integ_r;

   wire gap_full = (gap_r == {GAP_W{1'b1}});

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_r   <= GAP_ZERO;
         integ_r <= GAP_ZERO;
      end else begin
         gap_r   <= sp_take ? GAP_ZERO : (gap_full ? gap_r : gap_r + GAP_W'(1));
         integ_r <= sp_take ? gap_r : integ_r;
      end
   end

   assign video_out    = video_r;
   assign line_active  = reading;
   assign integ_cycles = integ_r;

   // ************************************************************
   // Checks
   // ************************************************************
   logic [ADDR_W:0] out_cnt_r;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_cnt_r <= '0;
      end else if (sp_take) begin
         out_cnt_r <= '0;
      end else if (step) begin
         out_cnt_r <= out_cnt_r + (ADDR_W+1)'(1);
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   property p_seg_range;
      seg_r < SEG_W'(SEG_N);
   endproperty
   a_seg_range: assert property (p_seg_range) else $error("segment index out of range");

   property p_line_count;
      step && pix_last |-> out_cnt_r == (ADDR_W+1)'(LINE_PIX - 1);
   endproperty
   a_line_count: assert property (p_line_count) else $error("line did not hold the full pixel count");

   property p_first_addr;
      step && state_r == LSR_ARMED |-> rd_addr == ADDR_ZERO;
   endproperty
   a_first_addr: assert property (p_first_addr) else $error("scan did not begin at connector end");

   property p_frozen;
      mem_we |-> state_r == LSR_IDLE;
   endproperty
   a_frozen: assert property (p_frozen) else $error("detector memory written during readout");

   property p_addr_step;
      step && !pix_last |=> rd_addr == $past(rd_addr) + ADDR_W'(1);
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("shift position did not advance by one");

   property p_armed;
      sp_take |=> state_r == LSR_ARMED && !video_r.strobe;
   endproperty
   a_armed: assert property (p_armed) else $error("start pulse not accepted");

   property p_first_next;
      pc_fall && !sp_take && state_r == LSR_ARMED |=> video_r.strobe && video_r.first;
   endproperty
   a_first_next: assert property (p_first_next) else $error("first pixel missing on next clock");

   property p_strobe_cause;
      video_r.strobe |-> $past(pc_fall) && !$past(sp_take);
   endproperty
   a_strobe_cause: assert property (p_strobe_cause) else $error("video strobe without pixel clock");

   property p_hold;
      !video_r.strobe |-> $stable(video_r.level);
   endproperty
   a_hold: assert property (p_hold) else $error("video level moved between pixel clocks");

   property p_period;
      sp_take |=> gap_r == GAP_ZERO ##1 gap_r == GAP_W'(1) || sp_take;
   endproperty
   a_period: assert property (p_period) else $error("line period counter not restarted");

endmodule : lsr_readout

// ### tb/lsr_ctrl_model.sv
`timescale 1ns/1ps
// ****
// Scanner controller with line buffer
// ****
module lsr_ctrl_model (
   // Clock
   input  wire logic          ref_clk,
   // Paper sensor and pacing
   input  wire logic          paper_present,
   input  wire logic [3:0]    low_len,
   // Sensor pins
   output logic               pixel_clock,
   output logic               line_start_pulse,
   input  lsr_pkg::lsr_video_t video_out,
   // Status
   output int                 lines_done,
   output int                 cap_n,
   output int                 start_gap
);
   import lsr_pkg::*;
   logic [PIX_W-1:0] lbuf  [LINE_PIX];
   logic [1:0]       flags [LINE_PIX];
   int               cyc;
   int               t_last;

   always @(posedge ref_clk) cyc <= cyc + 1;

   // Capture count is owned here alone; a raised start pulse opens a new line
   always @(posedge ref_clk) begin
      if (line_start_pulse === 1'b1) begin
         cap_n <= 0;
      end else if (video_out.strobe === 1'b1) begin
         if (cap_n < LINE_PIX) begin
            lbuf[cap_n]  <= video_out.level;
            flags[cap_n] <= {video_out.first, video_out.last};
         end
         cap_n <= cap_n + 1;
      end
   end

   // Clock stands low between lines
   task automatic run_line;
      int f;
      line_start_pulse <= 1'b1;
      start_gap        <= cyc - t_last;
      t_last = cyc;
      // Three surplus falls show that the line stops by itself
      for (f = 0; f < LINE_PIX + 4; f++) begin
         pixel_clock <= 1'b1;
         repeat (2) @(posedge ref_clk);
         pixel_clock <= 1'b0;
         repeat (low_len) @(posedge ref_clk);
         line_start_pulse <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      lines_done <= lines_done + 1;
      repeat (4) @(posedge ref_clk);
   endtask : run_line

   initial begin
      pixel_clock      = 1'b0;
      line_start_pulse = 1'b0;
      lines_done       = 0;
      start_gap        = 0;
      t_last           = 0;
      forever begin
         @(posedge ref_clk);
         if (paper_present === 1'b1) run_line();
      end
   end
endmodule : lsr_ctrl_model

// ### tb/lsr_readout_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
// ****
// Readout bench
// ****
module lsr_readout_tb;
   import lsr_pkg::*;
   logic               ref_clk;
   logic               reset_n;
   logic               det_valid;
   logic               det_ready;
   logic [PIX_W-1:0]   det_level;
   logic               paper_present;
   logic [3:0]         low_len;
   logic               pixel_clock;
   logic               line_start_pulse;
   lsr_video_t         video_out;
   logic               line_active;
   logic [GAP_W-1:0]   integ_cycles;
   int                 lines_done;
   int                 cap_n;
   int                 start_gap;
   int                 mismatches;
   int                 total_checks;
   int                 i;
   int                 acc;

   lsr_readout u_lsr_readout (.ref_clk(ref_clk), .reset_n(reset_n), .pixel_clock(pixel_clock),
      .line_start_pulse(line_start_pulse), .det_valid(det_valid), .det_ready(det_ready),
      .det_level(det_level), .video_out(video_out), .line_active(line_active), .integ_cycles(integ_cycles));
   lsr_ctrl_model u_lsr_ctrl_model (.ref_clk(ref_clk), .paper_present(paper_present), .low_len(low_len),
      .pixel_clock(pixel_clock), .line_start_pulse(line_start_pulse), .video_out(video_out),
      .lines_done(lines_done), .cap_n(cap_n), .start_gap(start_gap));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Segment bits mixed in so a wrong segment order shows
   function automatic logic [PIX_W-1:0] pat(input int k);
      return 8'(k ^ (k >> 5));
   endfunction : pat

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic wait_lines(input int n);
      int k;
      for (k = 0; k < 30000 && lines_done != n; k++) @(posedge ref_clk);
      if (lines_done != n) begin
         mismatches++;
         print_verdict();
      end
   endtask : wait_lines

   task automatic t_reset;
      #50;
      `CHK(video_out, VIDEO_RESET)
      `CHK(line_active, 1'b0)
      `CHK(integ_cycles, GAP_ZERO)
      `CHK(det_ready, 1'b1)
      // Back onto the rising edge so later stimulus stays edge aligned
      @(posedge ref_clk);
   endtask : t_reset

   task automatic t_load;
      int k;
      int n;
      for (k = 0; k < LINE_PIX; k++) begin
         det_valid <= 1'b1;
         det_level <= pat(k);
         for (n = 0; n < 100; n++) begin
            #50;
            acc = det_ready;
            @(posedge ref_clk);
            if (acc == 1) break;
         end
         if (acc != 1) begin
            mismatches++;
            print_verdict();
         end
      end
      det_valid <= 1'b0;
      repeat (60) @(posedge ref_clk);
      `CHK(line_active, 1'b0)
   endtask : t_load

   // Memory is frozen during readout, so the FIFO must refuse after its depth
   task automatic t_fill;
      for (i = 0; i < 200 && line_active !== 1'b1; i++) @(posedge ref_clk);
      if (line_active !== 1'b1) begin
         mismatches++;
         print_verdict();
      end
      acc = 0;
      det_valid <= 1'b1;
      for (i = 0; i < 40; i++) begin
         det_level <= pat(acc);
         #50;
         if (det_ready === 1'b1) acc++;
         @(posedge ref_clk);
      end
      det_valid <= 1'b0;
      `CHK(acc, FIFO_DEPTH)
      `CHK(line_active, 1'b1)
   endtask : t_fill

   task automatic chk_line;
      `CHK(cap_n, LINE_PIX)
      `CHK(u_lsr_ctrl_model.flags[0], 2'b10)
      `CHK(u_lsr_ctrl_model.flags[LINE_PIX-1], 2'b01)
      `CHK(line_active, 1'b0)
      for (i = 0; i < LINE_PIX; i++) `CHK(u_lsr_ctrl_model.lbuf[i], pat(i))
   endtask : chk_line

   task automatic t_two_lines;
      paper_present <= 1'b1;
      t_fill();
      wait_lines(1);
      low_len <= 4'h9;
      chk_line();
      `CHK(det_ready, 1'b1)
      wait_lines(2);
      paper_present <= 1'b0;
      chk_line();
      `CHK((integ_cycles >= start_gap - 1) && (integ_cycles <= start_gap + 1), 1'b1)
      repeat (200) @(posedge ref_clk);
      `CHK(lines_done, 2)
      `CHK(line_active, 1'b0)
   endtask : t_two_lines

   initial begin
      mismatches    = 0;
      total_checks  = 0;
      reset_n       = 1'b0;
      det_valid     = 1'b0;
      det_level     = PIX_ZERO;
      paper_present = 1'b0;
      low_len       = 4'h5;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_load();
      t_two_lines();
      print_verdict();
   end
endmodule : lsr_readout_tb
